// *** src/etmh_timer.sv ***
// 8-bit compare timer with period and buffered duty compare registers
// ==========================================================================
`timescale 1ns/100ps
`include "etmh_regs.svh"

module etmh_timer
  import etmh_pkg::*;
#(
  parameter bit CARRIER_EN = 1'b0,
  parameter int PRE_W      = `ETMH_PRE_W
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        COMPANION_EVENT_COUNTER,
  output logic             TIMER_OUTPUT_PIN_O,
  output logic             TIMER_OUTPUT_PIN_OE,
  output logic             TIMER_MATCH_INTERRUPT
);

  // ==========================================================================
  // state
  etmh_mode_type   timer_h_mode_control;
  etmh_mode_type   next_timer_h_mode_control;
  logic [7:0]      period_compare;
  logic [7:0]      next_period_compare;
  logic [7:0]      duty_compare;
  logic [7:0]      next_duty_compare;
  logic [7:0]      duty_active;
  logic [7:0]      next_duty_active;
  logic [7:0]      count;
  logic [7:0]      next_count;
  logic            out_level;
  logic            next_out_level;
  logic            irq;
  logic            next_irq;
  logic [7:0]      rdata;
  logic [7:0]      next_rdata;

  // ==========================================================================
  // decode
  logic            tick;
  logic            run;
  etmh_opmode_type op;
  logic            pwm_mode;
  logic            carrier_mode;
  logic            period_match;
  logic            duty_hit;
  logic            duty_match;
  logic            wr_mode;
  logic            wr_period;
  logic            wr_duty;

  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
    addr_hit = (addr == target);
  endfunction

  // ==========================================================================
  // count clock
  etmh_prescaler #(
    .PRE_W (PRE_W)
  ) u_prescaler (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .sel       (etmh_clksel_type'(timer_h_mode_control.clock_select_field)),
    .companion (COMPANION_EVENT_COUNTER),
    .tick      (tick)
  );

  always_comb begin
    run          = timer_h_mode_control.count_enable_bit;
    op           = etmh_opmode_type'(timer_h_mode_control.operating_mode_field);
    // prohibited codes fall back to interval behaviour
    pwm_mode     = (op == ETMH_MODE_PWM);
    carrier_mode = CARRIER_EN && (op == ETMH_MODE_CARRIER);
    wr_mode      = REG_WR && addr_hit(REG_ADDR, `ETMH_MODE_ADDR);
    wr_period    = REG_WR && addr_hit(REG_ADDR, `ETMH_PERIOD_ADDR);
    wr_duty      = REG_WR && addr_hit(REG_ADDR, `ETMH_DUTY_ADDR);
    period_match = run && tick && (count == period_compare);
    duty_hit     = run && tick && (count == duty_active);
    // interval mode never sees the duty comparator
    duty_match   = duty_hit && (pwm_mode || carrier_mode);
  end

  // ==========================================================================
  // registers written by software
  always_comb begin
    next_timer_h_mode_control = timer_h_mode_control;
    next_period_compare       = period_compare;
    next_duty_compare         = duty_compare;
    next_duty_active          = duty_active;
    if (wr_mode) begin
      // other bits are trusted to stay put while running
      next_timer_h_mode_control = etmh_mode_type'(REG_WDATA);
    end
    if (wr_period && !run) begin
      // a running period register cannot be rewritten; write is dropped
      next_period_compare = REG_WDATA;
    end
    if (wr_duty) begin
      next_duty_compare = REG_WDATA;
    end
    if (!run && wr_duty) begin
      // stopped: a write takes effect at once, ready for the restart
      next_duty_active = REG_WDATA;
    end else if (duty_hit && !wr_duty) begin
      next_duty_active = duty_compare;
    end
    // duty_hit with wr_duty leaves duty_active as it is
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      timer_h_mode_control <= etmh_mode_type'(`ETMH_MODE_RESET);
      period_compare       <= `ETMH_COMPARE_RESET;
      duty_compare         <= `ETMH_COMPARE_RESET;
      duty_active          <= `ETMH_COMPARE_RESET;
    end else begin
      timer_h_mode_control <= next_timer_h_mode_control;
      period_compare       <= next_period_compare;
      duty_compare         <= next_duty_compare;
      duty_active          <= next_duty_active;
    end
  end

  // ==========================================================================
  // counter
  always_comb begin
    next_count = count;
    if (!run) begin
      next_count = `ETMH_COUNT_RESET;
    end else if (tick) begin
      if (period_match || (duty_match && carrier_mode)) begin
        next_count = `ETMH_COUNT_RESET;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      count <= `ETMH_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // ==========================================================================
  // output flip-flop and interrupt
  always_comb begin
    next_out_level = out_level;
    if (!run) begin
      next_out_level = timer_h_mode_control.output_default_level;
    end else begin
      // duty and period equal in PWM: two toggles cancel
      next_out_level = out_level ^ period_match ^ (duty_match && pwm_mode);
    end
    next_irq = period_match || (duty_match && carrier_mode);
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      out_level <= 1'b0;
      irq       <= 1'b0;
    end else begin
      out_level <= next_out_level;
      irq       <= next_irq;
    end
  end

  assign TIMER_OUTPUT_PIN_O    = out_level;
  assign TIMER_OUTPUT_PIN_OE   = timer_h_mode_control.output_enable_bit;
  assign TIMER_MATCH_INTERRUPT = irq;

  // ==========================================================================
  // read port: duty reads the buffered value, not the active one
  always_comb begin
    next_rdata = rdata;
    if (REG_RD) begin
      if (addr_hit(REG_ADDR, `ETMH_MODE_ADDR)) begin
        next_rdata = timer_h_mode_control;
      end else if (addr_hit(REG_ADDR, `ETMH_PERIOD_ADDR)) begin
        next_rdata = period_compare;
      end else if (addr_hit(REG_ADDR, `ETMH_DUTY_ADDR)) begin
        next_rdata = duty_compare;
      end else begin
        next_rdata = `ETMH_READ_IDLE;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rdata <= `ETMH_READ_IDLE;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign REG_RDATA = rdata;

endmodule

// *** src/etmh_regs.svh ***
// register addresses, reset values and divider constants of the timer
`ifndef ETMH_REGS_SVH
`define ETMH_REGS_SVH

// ==========================================================================
// register addresses
`define ETMH_MODE_ADDR      16'hFF69
`define ETMH_PERIOD_ADDR    16'hFF6A
`define ETMH_DUTY_ADDR      16'hFF6B

// ==========================================================================
// reset values
`define ETMH_MODE_RESET     8'h00
`define ETMH_COMPARE_RESET  8'h00
`define ETMH_COUNT_RESET    8'h00
`define ETMH_READ_IDLE      8'h00

// ==========================================================================
// prescaler: width and tap masks for peripheral clock divided by 1,2,4,64,1024
`define ETMH_PRE_W          10
`define ETMH_MASK_DIV1      10'h000
`define ETMH_MASK_DIV2      10'h001
`define ETMH_MASK_DIV4      10'h003
`define ETMH_MASK_DIV64     10'h03F
`define ETMH_MASK_DIV1024   10'h3FF

`endif

// *** src/etmh_pkg.sv ***
// types shared by the timer and its prescaler
package etmh_pkg;

  // ==========================================================================
  // mode register layout
  typedef struct packed {
    logic       count_enable_bit;
    logic [2:0] clock_select_field;
    logic [1:0] operating_mode_field;
    logic       output_default_level;
    logic       output_enable_bit;
  } etmh_mode_type;

  // ==========================================================================
  // operating modes
  typedef enum logic [1:0] {
    ETMH_MODE_INTERVAL = 2'h0,
    ETMH_MODE_CARRIER  = 2'h1,
    ETMH_MODE_PWM      = 2'h2,
    ETMH_MODE_BAD      = 2'h3
  } etmh_opmode_type;

  // ==========================================================================
  // count clock sources
  typedef enum logic [2:0] {
    ETMH_CLK_DIV1      = 3'h0,
    ETMH_CLK_DIV2      = 3'h1,
    ETMH_CLK_DIV4      = 3'h2,
    ETMH_CLK_DIV64     = 3'h3,
    ETMH_CLK_DIV1024   = 3'h4,
    ETMH_CLK_COMPANION = 3'h5,
    ETMH_CLK_BAD6      = 3'h6,
    ETMH_CLK_BAD7      = 3'h7
  } etmh_clksel_type;

endpackage

// *** src/etmh_prescaler.sv ***
// count clock prescaler: free divider taps plus companion timer edge
`timescale 1ns/100ps
`include "etmh_regs.svh"

module etmh_prescaler
  import etmh_pkg::*;
#(
  parameter int PRE_W = `ETMH_PRE_W
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire etmh_clksel_type sel,
  input  wire logic            companion,
  output logic                 tick
);

  logic [PRE_W-1:0] div;
  logic [PRE_W-1:0] next_div;
  logic             comp_meta;
  logic             comp_sync;
  logic             comp_last;
  logic [PRE_W-1:0] mask;
  logic             valid_sel;

  // ==========================================================================
  // tap selection
  function automatic logic [PRE_W-1:0] tap_mask(input etmh_clksel_type s);
    unique case (s)
      ETMH_CLK_DIV1:    tap_mask = PRE_W'(`ETMH_MASK_DIV1);
      ETMH_CLK_DIV2:    tap_mask = PRE_W'(`ETMH_MASK_DIV2);
      ETMH_CLK_DIV4:    tap_mask = PRE_W'(`ETMH_MASK_DIV4);
      ETMH_CLK_DIV64:   tap_mask = PRE_W'(`ETMH_MASK_DIV64);
      ETMH_CLK_DIV1024: tap_mask = PRE_W'(`ETMH_MASK_DIV1024);
      default:          tap_mask = '0;
    endcase
  endfunction

  // ==========================================================================
  // free running divider
  always_comb begin
    next_div = div + PRE_W'(1);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div       <= '0;
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      comp_last <= 1'b0;
    end else begin
      div       <= next_div;
      comp_meta <= companion;
      comp_sync <= comp_meta;
      comp_last <= comp_sync;
    end
  end

  // ==========================================================================
  // tick: one cycle per count clock edge; prohibited codes never tick
  always_comb begin
    mask      = tap_mask(sel);
    valid_sel = (sel <= ETMH_CLK_DIV1024);
    if (sel == ETMH_CLK_COMPANION) begin
      tick = comp_sync & ~comp_last;
    end else begin
      tick = valid_sel & ((div & mask) == mask);
    end
  end

endmodule

// *** testbench/etmh_monitor.sv ***
// port-level assertion checker for the compare timer
`timescale 1ns/100ps
`include "etmh_regs.svh"

module etmh_monitor (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        TIMER_OUTPUT_PIN_O,
  input wire logic        TIMER_OUTPUT_PIN_OE,
  input wire logic        TIMER_MATCH_INTERRUPT
);
  // ==========================================================================
  // shadow state
  logic [7:0] mode;
  logic [7:0] per;
  logic [1:0] stab;
  logic       p1;
  logic       p2;
  logic       wm;
  logic       run;
  assign wm = REG_WR && REG_ADDR == `ETMH_MODE_ADDR;
  // checks start four cycles after a mode write, so late match effects settle
  assign run = mode[7] && stab == 2'h3;
  always_ff @(posedge REF_CLK) begin
    p1 <= TIMER_OUTPUT_PIN_O;
    p2 <= p1;
    if (!RST_N) begin
      mode <= 8'h00;
      per <= 8'h00;
      stab <= 2'h0;
    end else begin
      if (wm) mode <= REG_WDATA;
      if (REG_WR && REG_ADDR == `ETMH_PERIOD_ADDR && !mode[7]) per <= REG_WDATA;
      if (wm) stab <= 2'h0;
      else if (stab != 2'h3) stab <= stab + 2'h1;
    end
  end

  // ==========================================================================
  // assertions
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  chk_oe_mode: assert property (
    wm |=> TIMER_OUTPUT_PIN_OE == $past(REG_WDATA[0])) else $error("oe not from mode");
  chk_stop_level: assert property (
    !mode[7] && stab == 2'h3 |-> TIMER_OUTPUT_PIN_O == mode[1]) else $error("idle level");
  chk_stop_quiet: assert property (
    !mode[7] && stab == 2'h3 |-> !TIMER_MATCH_INTERRUPT) else $error("irq while stopped");
  chk_toggle_irq: assert property (
    run && mode[3:2] == 2'h0 && TIMER_OUTPUT_PIN_O != p1 |-> ##[0:2] TIMER_MATCH_INTERRUPT)
    else $error("toggle without irq");
  chk_irq_toggle: assert property (
    TIMER_MATCH_INTERRUPT && run && mode[3:2] == 2'h0 |-> TIMER_OUTPUT_PIN_O != p1 || p1 != p2)
    else $error("irq without toggle");
  chk_bad_clock: assert property (
    run && mode[6:5] == 2'h3 |-> !TIMER_MATCH_INTERRUPT) else $error("bad clock ticks");
  chk_period_keep: assert property (
    REG_RD && REG_ADDR == `ETMH_PERIOD_ADDR |=> REG_RDATA == $past(per)) else $error("period");
  chk_mode_read: assert property (
    REG_RD && REG_ADDR == `ETMH_MODE_ADDR |=> REG_RDATA == $past(mode)) else $error("mode read");
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the compare timer
`timescale 1ns/100ps
`include "etmh_regs.svh"

module tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [2:0]  ccnt = 3'h0;
  logic        pin_o;
  logic        oe;
  logic        irq;
  int          errors = 0;
  int          samples_checked = 0;
  int          gap;
  int          tog;
  int          first;
  int          f0;
  int          divs [6] = '{1, 2, 4, 64, 1024, 8};

  always #5 ref_clk = ~ref_clk;
  // companion timer free-running before use, 50% duty, period 8
  always @(posedge ref_clk) ccnt <= ccnt + 3'h1;

  etmh_timer #(.CARRIER_EN(1'b1)) u_etmh_timer (
    .REF_CLK(ref_clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .COMPANION_EVENT_COUNTER(ccnt[2]), .TIMER_OUTPUT_PIN_O(pin_o),
    .TIMER_OUTPUT_PIN_OE(oe), .TIMER_MATCH_INTERRUPT(irq));

  // ==========================================================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
    cyc(1);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // cycles, toggles and first toggle between two interrupts
  task automatic span(input int lim);
    int  n;
    logic p;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    gap = 0;
    tog = 0;
    first = 0;
    p = pin_o;
    do begin
      cyc(1);
      gap++;
      if (pin_o !== p) begin
        tog++;
        if (first == 0) first = gap;
      end
      p = pin_o;
    end while (irq !== 1'b1 && gap < lim);
    if (n >= lim || gap >= lim) begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      complete_run();
    end
  endtask
  task automatic quiet(input int c);
    int n;
    n = 0;
    repeat (c) begin
      cyc(1);
      if (irq !== 1'b0) n++;
    end
    chk(n, 0);
  endtask

  // ==========================================================================
  // tests
  initial begin
    cyc(8);
    rst_n = 1'b1;
    rd(`ETMH_MODE_ADDR, 8'h00);
    rd(`ETMH_PERIOD_ADDR, 8'h00);
    rd(`ETMH_DUTY_ADDR, 8'h00);
    rd(16'hFF6F, 8'h00);
    $display("test reset done");
    wr(`ETMH_PERIOD_ADDR, 8'h03);
    wr(`ETMH_DUTY_ADDR, 8'h01);
    wr(`ETMH_MODE_ADDR, 8'h81);
    span(100);
    chk(gap, 4);
    chk(tog, 1);
    wr(`ETMH_PERIOD_ADDR, 8'h09);
    rd(`ETMH_PERIOD_ADDR, 8'h03);
    chk(oe, 1);
    wr(`ETMH_MODE_ADDR, 8'h01);
    wr(`ETMH_MODE_ADDR, 8'h03);
    cyc(2);
    chk(pin_o, 1);
    quiet(20);
    wr(`ETMH_MODE_ADDR, 8'h02);
    chk(oe, 0);
    $display("test interval done");
    for (int k = 0; k < 6; k++) begin
      wr(`ETMH_MODE_ADDR, 8'h00);
      wr(`ETMH_PERIOD_ADDR, 8'h01);
      wr(`ETMH_MODE_ADDR, {1'b1, 3'(k), 4'h1});
      span(5000);
      chk(gap, 2 * divs[k]);
      wr(`ETMH_MODE_ADDR, {1'b0, 3'(k), 4'h1});
    end
    wr(`ETMH_MODE_ADDR, 8'h00);
    wr(`ETMH_MODE_ADDR, 8'hE1);
    quiet(50);
    $display("test clock done");
    wr(`ETMH_MODE_ADDR, 8'h61);
    wr(`ETMH_MODE_ADDR, 8'h00);
    wr(`ETMH_PERIOD_ADDR, 8'h09);
    wr(`ETMH_DUTY_ADDR, 8'h03);
    wr(`ETMH_MODE_ADDR, 8'h89);
    span(100);
    chk(gap, 10);
    chk(tog, 2);
    f0 = first;
    wr(`ETMH_DUTY_ADDR, 8'h06);
    rd(`ETMH_DUTY_ADDR, 8'h06);
    span(100);
    span(100);
    chk(first - f0, 3);
    // write lands on the duty match edge; active value stays at 6
    cyc(6);
    wr(`ETMH_DUTY_ADDR, 8'h02);
    span(100);
    chk(first, 7);
    span(100);
    chk(first, 3);
    $display("test pwm done");
    wr(`ETMH_MODE_ADDR, 8'h09);
    wr(`ETMH_MODE_ADDR, 8'h00);
    wr(`ETMH_PERIOD_ADDR, 8'hC8);
    wr(`ETMH_DUTY_ADDR, 8'h04);
    wr(`ETMH_MODE_ADDR, 8'h85);
    span(100);
    chk(gap, 5);
    chk(tog, 0);
    rd(`ETMH_MODE_ADDR, 8'h85);
    $display("test carrier done");
    complete_run();
  end
endmodule

bind etmh_timer etmh_monitor u_etmh_monitor (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .TIMER_OUTPUT_PIN_O(TIMER_OUTPUT_PIN_O), .TIMER_OUTPUT_PIN_OE(TIMER_OUTPUT_PIN_OE),
  .TIMER_MATCH_INTERRUPT(TIMER_MATCH_INTERRUPT));
